// ### verilog/aecu_pkg.sv
/*
  Constants and types for the add-extended carry unit.
  Assumes a 32-bit datapath and a 32-entry general register file.
*/
package aecu_pkg;

  // ---------------------------------------------------------------
  // Datapath sizes
  // ---------------------------------------------------------------
  localparam int unsigned AECU_XLEN   = 32;
  localparam int unsigned AECU_RIDX_W = 5;
  localparam int unsigned AECU_NREGS  = 32;

  // ---------------------------------------------------------------
  // Addend constants
  // ---------------------------------------------------------------
  localparam logic [31:0] AECU_MINUS_ONE = 32'hffff_ffff;
  localparam logic [31:0] AECU_ZERO      = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] AECU_GREG_RST  = 32'h0000_0000;
  localparam logic [3:0]  AECU_CRF_RST   = 4'h0;
  localparam logic [2:0]  AECU_IRQ_RST   = 3'h0;

  // ---------------------------------------------------------------
  // Register port: offsets (word addresses) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] AECU_OFF_GREG0  = 8'h00; // 0x00..0x1f regs
  localparam logic [7:0] AECU_OFF_FLAGS  = 8'h20;
  localparam logic [7:0] AECU_OFF_IRQST  = 8'h21;
  localparam logic [7:0] AECU_OFF_IRQMSK = 8'h22;

  // Flags word: ca, ov, so, crf0 (lt, gt, eq, so)
  localparam int unsigned AECU_FLD_CA  = 0;
  localparam int unsigned AECU_FLD_OV  = 1;
  localparam int unsigned AECU_FLD_SO  = 2;
  localparam int unsigned AECU_FLD_CRF = 4;  // 4 bits: lt gt eq so

  // Interrupt events
  localparam int unsigned AECU_EV_DONE = 0;
  localparam int unsigned AECU_EV_OV   = 1;
  localparam int unsigned AECU_EV_CA   = 2;

  // ---------------------------------------------------------------
  // Operation select
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    AECU_OP_MINUS_ONE = 1'b0,
    AECU_OP_ZERO      = 1'b1
  } aecu_op_type;

endpackage

// ### verilog/aecu_adder.sv
/*
  Combinational 32-bit add-extended core with carry and overflow.
  Assumes operands arrive from flip-flops of the same clock.
*/
`timescale 1ns/1ps
module aecu_adder (
  input  wire logic [31:0]         src_val,   // Source operand
  input  wire aecu_pkg::aecu_op_type op,      // Addend select
  input  wire logic                carry_in,  // Current carry_flag
  output logic      [31:0]         sum,       // 32-bit result
  output logic                     carry_out, // Carry out of msb
  output logic                     ovf        // Signed overflow
);
  import aecu_pkg::*;

  logic [31:0] addend;
  logic [32:0] wide;

  always_comb begin
    addend = (op == AECU_OP_MINUS_ONE) ? AECU_MINUS_ONE
                                       : AECU_ZERO;
    wide   = {1'b0, src_val} + {1'b0, addend} + {32'h0000_0000, carry_in};
    sum       = wide[31:0];
    carry_out = wide[32];
    // Same-sign operands giving an opposite-sign result
    ovf = (src_val[31] == addend[31]) && (sum[31] != src_val[31]);
  end

endmodule // aecu_adder

// ### verilog/aecu_top.sv
/*
  Add-extended carry unit: general registers, fixed-point flags,
  condition field 0, and a small register port with interrupts.
  Assumes the decoder gives one-cycle issue strobes on mclk and
  software uses the plain register port on the same clock.
*/
// Added by the designer: the register addresses and the strobed register port.
// Overview of operation
// - Add-to-minus-one writes source plus carry plus all ones to target.
// - Add-to-zero writes source plus carry plus zero to target.
// - Every form updates carry from the addition result.
// - Overflow-enable set updates overflow and summary overflow; else hold.
// - Record set updates condition field 0 from result; else hold.
// - Four variants per operation from overflow-enable and record bits.
// - No privilege needed; general registers are source and target.
`timescale 1ns/1ps
module aecu_top (
  input  wire logic                 mclk,        // Core clock
  input  wire logic                 rst_b,       // Async reset, low
  input  wire logic                 issue,       // Execute strobe
  input  wire aecu_pkg::aecu_op_type op,         // Operation select
  input  wire logic [4:0]           source_reg,  // Source index
  input  wire logic [4:0]           target_reg,  // Target index
  input  wire logic                 oe_bit,      // Overflow enable
  input  wire logic                 record_bit,  // Record enable
  input  wire logic [7:0]           reg_addr,    // Register address
  input  wire logic [31:0]          reg_wdata,   // Write data
  input  wire logic                 reg_wr,      // Write strobe
  input  wire logic                 reg_rd,      // Read strobe
  output logic      [31:0]          reg_rdata,   // Read data
  output logic                      carry_flag,  // Carry flag
  output logic                      overflow_flag, // Overflow flag
  output logic                      summary_ovf, // Summary overflow
  output logic                      less_than_zero_bit,    // Field 0 lt
  output logic                      greater_than_zero_bit, // Field 0 gt
  output logic                      equal_zero_bit,        // Field 0 eq
  output logic                      crf_summary, // Field 0 so copy
  output logic                      done,        // Result written
  output logic                      irq          // Level interrupt
);
  import aecu_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [AECU_NREGS-1:0][31:0] general_register;
    logic                        ca;
    logic                        ov;
    logic                        so;
    logic [3:0]                  crf;   // lt gt eq so
    logic [2:0]                  irq_st;
    logic [2:0]                  irq_msk;
    logic [31:0]                 rdata;
    logic                        done;
  } aecu_state_type;

  aecu_state_type st_q;
  aecu_state_type st_d;

  logic [31:0] sum;
  logic        carry_out;
  logic        ovf;
  logic [2:0]  ev;
  logic        new_so;

  // Register index decode, used by both read and write paths
  function automatic logic is_greg(input logic [7:0] a);
    return a < (AECU_OFF_GREG0 + 8'(AECU_NREGS));
  endfunction

  // ---------------------------------------------------------------
  // Adder
  // ---------------------------------------------------------------
  aecu_adder u_adder (
    .src_val   (st_q.general_register[source_reg]),
    .op        (op),
    .carry_in  (st_q.ca),
    .sum       (sum),
    .carry_out (carry_out),
    .ovf       (ovf)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    ev        = 3'h0;
    new_so    = st_q.so;

    // Software writes first, so an issue in the same cycle wins
    if (reg_wr) begin
      if (is_greg(reg_addr)) begin
        st_d.general_register[reg_addr[4:0]] = reg_wdata;
      end else if (reg_addr == AECU_OFF_FLAGS) begin
        st_d.ca  = reg_wdata[AECU_FLD_CA];
        st_d.ov  = reg_wdata[AECU_FLD_OV];
        st_d.so  = reg_wdata[AECU_FLD_SO];
        st_d.crf = reg_wdata[AECU_FLD_CRF +: 4];
        new_so   = reg_wdata[AECU_FLD_SO];
      end else if (reg_addr == AECU_OFF_IRQST) begin
        st_d.irq_st = st_q.irq_st & ~reg_wdata[2:0];
      end else if (reg_addr == AECU_OFF_IRQMSK) begin
        st_d.irq_msk = reg_wdata[2:0];
      end
    end

    if (issue) begin
      st_d.general_register[target_reg] = sum;
      st_d.ca   = carry_out;
      st_d.done = 1'b1;
      ev[AECU_EV_DONE] = 1'b1;
      ev[AECU_EV_CA]   = carry_out;
      if (oe_bit) begin
        st_d.ov = ovf;
        new_so  = st_q.so | ovf;
        st_d.so = new_so;
        ev[AECU_EV_OV] = ovf;
      end
      if (record_bit) begin
        st_d.crf = {sum[31],
                    ~sum[31] & (sum != 32'h0000_0000),
                    sum == 32'h0000_0000,
                    new_so};
      end
    end

    // Set beats a simultaneous write-one-to-clear
    st_d.irq_st = st_d.irq_st | ev;

    st_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (is_greg(reg_addr)) begin
        st_d.rdata = st_q.general_register[reg_addr[4:0]];
      end else if (reg_addr == AECU_OFF_FLAGS) begin
        st_d.rdata[AECU_FLD_CA]      = st_q.ca;
        st_d.rdata[AECU_FLD_OV]      = st_q.ov;
        st_d.rdata[AECU_FLD_SO]      = st_q.so;
        st_d.rdata[AECU_FLD_CRF +: 4] = st_q.crf;
      end else if (reg_addr == AECU_OFF_IRQST) begin
        st_d.rdata[2:0] = st_q.irq_st;
      end else if (reg_addr == AECU_OFF_IRQMSK) begin
        st_d.rdata[2:0] = st_q.irq_msk;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.general_register <= {AECU_NREGS{AECU_GREG_RST}};
      st_q.ca      <= 1'b0;
      st_q.ov      <= 1'b0;
      st_q.so      <= 1'b0;
      st_q.crf     <= AECU_CRF_RST;
      st_q.irq_st  <= AECU_IRQ_RST;
      st_q.irq_msk <= AECU_IRQ_RST;
      st_q.rdata   <= 32'h0000_0000;
      st_q.done    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata             = st_q.rdata;
  assign carry_flag            = st_q.ca;
  assign overflow_flag         = st_q.ov;
  assign summary_ovf           = st_q.so;
  assign less_than_zero_bit    = st_q.crf[3];
  assign greater_than_zero_bit = st_q.crf[2];
  assign equal_zero_bit        = st_q.crf[1];
  assign crf_summary           = st_q.crf[0];
  assign done                  = st_q.done;
  assign irq                   = |(st_q.irq_st & st_q.irq_msk);

endmodule // aecu_top

// ### verification/aecu_monitor.sv
/* Port checks of the add-extended carry unit.
   Assumes the aecu_top ports and one clock domain. */
`timescale 1ns/1ps
module aecu_monitor (
  input wire logic        mclk,                  // Core clock
  input wire logic        rst_b,                 // Async reset, low
  input wire logic        issue,                 // Execute strobe
  input wire logic        oe_bit,                // Overflow enable
  input wire logic        record_bit,            // Record enable
  input wire logic        reg_wr,                // Write strobe
  input wire logic        reg_rd,                // Read strobe
  input wire logic [31:0] reg_rdata,             // Read data
  input wire logic        carry_flag,            // Carry flag
  input wire logic        overflow_flag,         // Overflow flag
  input wire logic        summary_ovf,           // Summary overflow
  input wire logic        less_than_zero_bit,    // Field 0 lt
  input wire logic        greater_than_zero_bit, // Field 0 gt
  input wire logic        equal_zero_bit,        // Field 0 eq
  input wire logic        crf_summary,           // Field 0 so copy
  input wire logic        done                   // Result written
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_quiet; !issue && !reg_wr; endsequence
  sequence s_no_ov; !reg_wr && !(issue && oe_bit); endsequence
  sequence s_no_cr; !reg_wr && !(issue && record_bit); endsequence
  AST_DONE: assert property (issue |=> done)
    else $error("no done after issue");
  AST_NO_DONE: assert property (!issue |=> !done)
    else $error("done without issue");
  AST_CA_HOLD: assert property (s_quiet |=> $stable(carry_flag))
    else $error("carry moved while idle");
  AST_OV_HOLD: assert property (s_no_ov |=>
    $stable({overflow_flag, summary_ovf})) else $error("overflow moved");
  AST_CR_HOLD: assert property (s_no_cr |=> $stable({
    less_than_zero_bit, greater_than_zero_bit, equal_zero_bit,
    crf_summary})) else $error("field 0 moved");
  AST_SO_STICKY: assert property (summary_ovf && !reg_wr |=> summary_ovf)
    else $error("summary overflow dropped");
  AST_OV_SO: assert property (issue && oe_bit |=>
    !overflow_flag || summary_ovf) else $error("overflow without summary");
  AST_CR_SET: assert property (issue && record_bit |=>
    $onehot({less_than_zero_bit, greater_than_zero_bit, equal_zero_bit})
    && crf_summary == summary_ovf) else $error("field 0 malformed");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
endmodule // aecu_monitor
bind aecu_top aecu_monitor u_mon (.mclk(mclk), .rst_b(rst_b),
  .issue(issue), .oe_bit(oe_bit), .record_bit(record_bit),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .carry_flag(carry_flag), .overflow_flag(overflow_flag),
  .summary_ovf(summary_ovf), .less_than_zero_bit(less_than_zero_bit),
  .greater_than_zero_bit(greater_than_zero_bit),
  .equal_zero_bit(equal_zero_bit), .crf_summary(crf_summary), .done(done));

// ### verification/aecu_decode_model.sv
/* Decoder stand-in: splits a word into the issue fields.
   Assumes the word changes just after a rising edge. */
`timescale 1ns/1ps
module aecu_decode_model (
  input  wire logic        valid,      // Word present
  input  wire logic [12:0] word,       // op oe rc src tgt
  output logic             issue,      // Execute strobe
  output aecu_pkg::aecu_op_type op,    // Operation select
  output logic [4:0]       source_reg, // Source index
  output logic [4:0]       target_reg, // Target index
  output logic             oe_bit,     // Overflow enable
  output logic             record_bit  // Record enable
);
  import aecu_pkg::*;
  assign issue = valid;
  assign op = aecu_op_type'(word[12]);
  assign {oe_bit, record_bit} = word[11:10];
  assign {source_reg, target_reg} = word[9:0];
endmodule // aecu_decode_model

// ### verification/aecu_top_bench.sv
/* Self-checking bench of the add-extended carry unit.
   Assumes the decoder model and the bound monitor. */
`timescale 1ns/1ps
module aecu_top_bench;
  import aecu_pkg::*;
  logic mclk = 0, rst_b = 0, iv = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic iss_seen = 0;
  logic [12:0] iw = '0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, exp_v, g[32], a, ad, r32;
  logic [31:0] cv[4] = '{32'h8000_0000, 32'hffff_ffff, 32'h7fff_ffff, 0};
  logic [15:0] lf = 16'haca3;
  logic [7:0]  f;
  logic [4:0]  s, t, sr, tr;
  logic [3:0]  cr = 0;
  logic [2:0]  st = 0, mk;
  logic ca = 0, ov = 0, so = 0, c, v, iss, oeb, rcb, cf, of, sf;
  logic lt, gt, eq, cs, done, irq;
  aecu_op_type dop;
  logic [31:0] exp_q[$];
  int n_errors = 0, check_count = 0;
  aecu_decode_model u_dec (.valid(iv), .word(iw), .issue(iss), .op(dop),
    .source_reg(sr), .target_reg(tr), .oe_bit(oeb), .record_bit(rcb));
  aecu_top u_dut (.mclk(mclk), .rst_b(rst_b), .issue(iss), .op(dop),
    .source_reg(sr), .target_reg(tr), .oe_bit(oeb), .record_bit(rcb),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carry_flag(cf),
    .overflow_flag(of), .summary_ovf(sf), .less_than_zero_bit(lt),
    .greater_than_zero_bit(gt), .equal_zero_bit(eq), .crf_summary(cs),
    .done(done), .irq(irq));
  initial forever #5 mclk = ~mclk;
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] o);
    check_count++;
    if (o !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, o);
    end
  endtask
  task automatic bus(logic w, logic r, logic [7:0] ad_i, logic [31:0] d);
    reg_wr <= w; reg_rd <= r; iv <= 1'b0; reg_addr <= ad_i; reg_wdata <= d;
    if (r) exp_q.push_back(d);
    @(posedge mclk);
  endtask
  task automatic ex(logic o, logic e, logic r, logic [4:0] si, logic [4:0] ti);
    iv <= 1'b1; iw <= {o, e, r, si, ti}; reg_wr <= 1'b0; reg_rd <= 1'b0;
    @(posedge mclk);
    a = g[si]; ad = o ? AECU_ZERO : AECU_MINUS_ONE;
    {c, r32} = {1'b0, a} + {1'b0, ad} + {32'h0, ca};
    v = (a[31] == ad[31]) && (r32[31] != a[31]);
    g[ti] = r32; ca = c; st = st | {c, e & v, 1'b1};
    if (e) begin ov = v; so = so | v; end
    if (r) cr = {r32[31], !r32[31] && r32 != 0, r32 == 0, so};
  endtask
  function automatic logic [31:0] fl();
    return {24'h0, cr, 1'b0, so, ov, ca};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    rd_seen  <= reg_rd;
    iss_seen <= iss;
  end
  // Registered outputs are compared mid-cycle, where they have settled
  always @(negedge mclk) begin
    if (rst_b) begin
      chk("done", {31'h0, iss_seen}, {31'h0, done});
    end
    if (rd_seen) begin
      exp_v = exp_q.pop_front();
      chk("rdata", exp_v, reg_rdata);
    end
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 32; i++) g[i] = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    bus(0, 1, AECU_OFF_FLAGS, 0);
    bus(0, 1, 8'hff, 0);
    for (int k = 0; k < 64; k++) begin
      s = rnd(); t = rnd(); f = rnd() & 8'hf7; mk = {3{k[3]}};
      bus(1, 0, {3'h0, s}, k < 4 ? cv[k] : {rnd(), rnd()});
      g[s] = reg_wdata;
      bus(1, 0, AECU_OFF_FLAGS, {24'h0, f});
      {cr, so, ov, ca} = {f[7:4], f[2:0]};
      bus(1, 0, AECU_OFF_IRQMSK, {29'h0, mk});
      ex(k[0], k[1], k[2], s, t);
      ex(k[0], k[1], k[2], t, t);
      bus(0, 1, {3'h0, t}, g[t]);
      bus(0, 1, AECU_OFF_FLAGS, fl());
      bus(0, 1, AECU_OFF_IRQST, {29'h0, st});
      #1 chk("irq", {31'h0, |(st & mk)}, {31'h0, irq});
      bus(1, 0, AECU_OFF_IRQST, {29'h0, st});
      st = 0;
      bus(0, 0, 8'h0, 0);
      #1 chk("irq", 0, {31'h0, irq});
      chk("pins", fl(), {24'h0, lt, gt, eq, cs, 1'b0, sf, of, cf});
    end
    conclude();
  end
endmodule // aecu_top_bench
